/* rtl/pwr_init_pkg.sv */
// shared constants, types and lookups of the power-on and initialisation sequencer
package pwr_init_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;

	// register byte addresses
	localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] REG_INT_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] REG_INT_MASK = 5'h0c;
	localparam logic [ADDR_W-1:0] REG_CLOCK = 5'h10;

	// control fields
	localparam int CTRL_OFF_BIT = 0;
	localparam int CTRL_AUTO_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// status fields
	localparam int STS_MAIN_BIT = 0;
	localparam int STS_READY_BIT = 1;
	localparam int STS_RTC_BIT = 2;
	localparam int STS_BATT_BIT = 3;
	localparam int STS_STRAP_LSB = 4;
	localparam int STS_RSVD_BIT = 7;
	localparam int STS_STATE_LSB = 8;

	// event bits of the interrupt status and mask registers
	localparam int EVT_CAUSE = 0;
	localparam int EVT_BATT_INHIBIT = 1;
	localparam int EVT_BATT_LOW = 2;
	localparam int EVT_RESET_BTN = 3;
	localparam int EVT_STRAP = 4;
	localparam int EVT_STRAP_RSVD = 5;
	localparam int N_EVT = 6;
	localparam logic [N_EVT-1:0] MASK_RESET = 6'h00;

	// timing
	localparam int CLK_FREQ_MHZ = 50;
	localparam int CHECK_TIME_NS = 10000;
	localparam int CHECK_CYCLES = (CHECK_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

	// clock field layout
	localparam int CLOCK_BUS_LSB = 0;
	localparam int CLOCK_CORE_LSB = 16;

	localparam int STRAP_W = 3;
	localparam logic [STRAP_W-1:0] STRAP_RESET = 3'h0;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_CHECK,
		ST_ON,
		ST_SPARE
	} seq_state_t;

	typedef struct packed {
		logic [15:0] core_khz;
		logic [15:0] bus_khz;
	} clk_pair_t;

	typedef struct packed {
		logic [STRAP_W-1:0] code;
		logic reserved;
		clk_pair_t pair;
	} strap_info_t;

	function automatic clk_pair_t clk_pair_of(input logic [STRAP_W-1:0] code);
		clk_pair_t p;
		p = '{core_khz: 16'h0000, bus_khz: 16'h0000};
		unique case (code)
			3'h5: p = '{core_khz: 16'd53600, bus_khz: 16'd6700};
			3'h4: p = '{core_khz: 16'd49200, bus_khz: 16'd6075};
			3'h3: p = '{core_khz: 16'd45400, bus_khz: 16'd5675};
			3'h2: p = '{core_khz: 16'd42100, bus_khz: 16'd5275};
			3'h1: p = '{core_khz: 16'd36900, bus_khz: 16'd9200};
			3'h0: p = '{core_khz: 16'd32800, bus_khz: 16'd8200};
			default: p = '{core_khz: 16'h0000, bus_khz: 16'h0000};
		endcase
		return p;
	endfunction

	function automatic logic strap_is_reserved(input logic [STRAP_W-1:0] code);
		return code[2] & code[1];
	endfunction

endpackage

/* rtl/pin_sync.sv */
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_reg <= INIT;
			sync_out <= INIT;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* rtl/clock_strap_latch.sv */
// latches the clock-select strap on release of the rtc reset and decodes it
`timescale 1ns/100ps
module clock_strap_latch
	import pwr_init_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic rtc_reset_n_in,
	input wire logic [pwr_init_pkg::STRAP_W-1:0] strap_in,
	output pwr_init_pkg::strap_info_t info_out,
	output logic captured_out
);
	logic rtc_last_reg;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// matches the synchroniser's reset level, so reset itself is no release
			rtc_last_reg <= 1'b1;
		end else begin
			rtc_last_reg <= rtc_reset_n_in;
		end
	end

	// capture only on the low-to-high edge; held afterwards while the pins serve the serial port
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			info_out <= '{code: STRAP_RESET, reserved: 1'b0, pair: clk_pair_of(STRAP_RESET)};
			captured_out <= 1'b0;
		end else begin
			captured_out <= rtc_reset_n_in & ~rtc_last_reg; // see (RL10)
			if (rtc_reset_n_in && !rtc_last_reg) begin // see (RL10) see (RL13)
				info_out.code <= strap_in;
				info_out.reserved <= strap_is_reserved(strap_in);
				info_out.pair <= clk_pair_of(strap_in); // see (RL11)
			end
		end
	end
endmodule

/* rtl/power_on_init_sequencer.sv */
// power-on and initialisation sequencer with avalon-mm register slave
//
// Contract
// (RL1) main power off: battery pin high means battery ok
// (RL2) main power on: battery pin low interrupts
// (RL3) drive main power enable for dc/dc converter
// (RL4) ready rises on cause, falls after battery check
// (RL5) power switch press is a power-on cause
// (RL6) agent pulls reset button input low when pressed
// (RL7) agent holds rtc reset low about 600 ms; the agent model holds it 30 clocks (RTC_LOW), 600 ns
// (RL8) rtc logic held reset while rtc reset low
// (RL9) carrier detect is also a power-on cause
// (RL10) clock strap captured on rtc reset rising edge
// (RL11) strap selects core and bus clock pair
// (RL12) codes 110 and 111 must not be strapped
// (RL13) captured strap held until next rtc release
`timescale 1ns/100ps
module power_on_init_sequencer
	import pwr_init_pkg::*;
#(
	parameter int CHECK_WAIT = pwr_init_pkg::CHECK_CYCLES
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic battery_inhibit_in,
	input wire logic power_switch_in,
	input wire logic reset_button_n_in,
	input wire logic rtc_reset_n_in,
	input wire logic carrier_detect_n_in,
	input wire logic [pwr_init_pkg::STRAP_W-1:0] clock_select_strap_in,
	input wire logic [pwr_init_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [pwr_init_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [pwr_init_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic main_power_enable_out,
	output logic ready_to_operate_out,
	output logic rtc_logic_reset_out,
	output logic [pwr_init_pkg::STRAP_W-1:0] clock_select_out,
	output pwr_init_pkg::clk_pair_t clock_pair_out,
	output logic irq_out
);
	import pwr_init_pkg::*;

	localparam int CNT_W = 16;

	initial begin
		if (CHECK_WAIT < 1 || CHECK_WAIT > 65535) $error("CHECK_WAIT out of range 1..65535");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic batt_sync;
	logic power_sync;
	logic rstbtn_n_sync;
	logic rtc_n_sync;
	logic cd_n_sync;
	logic [STRAP_W-1:0] strap_sync;

	// reset levels match the idle pins so that no false edge follows reset
	pin_sync #(.WIDTH(5), .INIT(5'h17)) u_sync_ctl (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.async_in({battery_inhibit_in, power_switch_in, reset_button_n_in, rtc_reset_n_in, carrier_detect_n_in}),
		.sync_out({batt_sync, power_sync, rstbtn_n_sync, rtc_n_sync, cd_n_sync})
	);

	pin_sync #(.WIDTH(STRAP_W), .INIT(STRAP_RESET)) u_sync_strap (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.async_in(clock_select_strap_in),
		.sync_out(strap_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// strap capture

	strap_info_t strap_info;
	logic strap_captured;

	clock_strap_latch u_strap (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.rtc_reset_n_in(rtc_n_sync),
		.strap_in(strap_sync),
		.info_out(strap_info),
		.captured_out(strap_captured)
	);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clock_select_out <= STRAP_RESET;
			clock_pair_out <= clk_pair_of(STRAP_RESET);
		end else begin
			clock_select_out <= strap_info.code; // see (RL13)
			clock_pair_out <= strap_info.pair; // see (RL11)
		end
	end

	// rtc logic reset follows the pin level
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rtc_logic_reset_out <= 1'b1;
		end else begin
			rtc_logic_reset_out <= ~rtc_n_sync; // see (RL8)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// edge detection on causes and alarms

	logic power_last_reg;
	logic cd_n_last_reg;
	logic rstbtn_n_last_reg;
	logic batt_last_reg;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			power_last_reg <= 1'b0;
			cd_n_last_reg <= 1'b1;
			rstbtn_n_last_reg <= 1'b1;
			batt_last_reg <= 1'b1;
		end else begin
			power_last_reg <= power_sync;
			cd_n_last_reg <= cd_n_sync;
			rstbtn_n_last_reg <= rstbtn_n_sync;
			batt_last_reg <= batt_sync;
		end
	end

	logic cause_power;
	logic cause_carrier;
	logic reset_press;
	logic batt_irq_fall;

	assign cause_power = power_sync & ~power_last_reg; // see (RL5)
	assign cause_carrier = ~cd_n_sync & cd_n_last_reg; // see (RL9)
	assign reset_press = ~rstbtn_n_sync & rstbtn_n_last_reg; // see (RL6)
	assign batt_irq_fall = ~batt_sync & batt_last_reg;

	////////////////////////////////////////////////////////////////////////////
	// control register and bus request decode

	logic [1:0] ctrl_reg;
	logic [N_EVT-1:0] int_status_reg;
	logic [N_EVT-1:0] int_mask_reg;
	logic bus_req;
	logic wr_take;
	logic wr_low;
	logic sw_power_off;

	assign bus_req = avs_read | avs_write;
	assign wr_take = avs_write & ~avs_waitrequest;
	assign wr_low = wr_take & avs_byteenable[0];
	assign sw_power_off = wr_low && avs_address == REG_CTRL && avs_writedata[CTRL_OFF_BIT];

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_low && avs_address == REG_CTRL) begin
			ctrl_reg <= {avs_writedata[CTRL_AUTO_BIT], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power sequencer

	seq_state_t state_reg;
	logic [CNT_W-1:0] wait_reg;
	logic check_done;
	logic batt_ok_evt;
	logic batt_bad_evt;
	logic batt_run_evt;

	assign check_done = state_reg == ST_CHECK && wait_reg == '0;
	assign batt_ok_evt = check_done & batt_sync; // see (RL1)
	assign batt_bad_evt = check_done & ~batt_sync; // see (RL1)
	assign batt_run_evt = state_reg == ST_ON && batt_irq_fall; // see (RL2)

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ST_OFF;
		end else if (!rtc_n_sync) begin
			state_reg <= ST_OFF; // see (RL8)
		end else begin
			unique case (state_reg)
				ST_OFF: begin
					if (cause_power || cause_carrier) begin // see (RL4)
						state_reg <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					if (batt_ok_evt) begin
						state_reg <= ST_ON;
					end else if (batt_bad_evt) begin
						state_reg <= ST_OFF;
					end
				end
				ST_ON: begin
					if (sw_power_off || (batt_run_evt && ctrl_reg[CTRL_AUTO_BIT])) begin // see (RL2)
						state_reg <= ST_OFF;
					end
				end
				default: begin
					state_reg <= ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wait_reg <= '0;
		end else if (state_reg != ST_CHECK) begin
			wait_reg <= CNT_W'(CHECK_WAIT - 1);
		end else if (wait_reg != '0) begin
			wait_reg <= wait_reg - 1'b1;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			main_power_enable_out <= 1'b0;
			ready_to_operate_out <= 1'b0;
		end else begin
			// power comes up on the same edge at which ready drops
			main_power_enable_out <= state_reg == ST_ON || (batt_ok_evt && rtc_n_sync); // see (RL3)
			ready_to_operate_out <= state_reg == ST_CHECK && !check_done; // see (RL4)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, mask and output

	logic [N_EVT-1:0] evt_vec;

	always_comb begin
		evt_vec = '0;
		evt_vec[EVT_CAUSE] = state_reg == ST_OFF && rtc_n_sync && (cause_power || cause_carrier);
		evt_vec[EVT_BATT_INHIBIT] = batt_bad_evt;
		evt_vec[EVT_BATT_LOW] = batt_run_evt;
		evt_vec[EVT_RESET_BTN] = reset_press;
		evt_vec[EVT_STRAP] = strap_captured;
		evt_vec[EVT_STRAP_RSVD] = strap_captured & strap_info.reserved;
	end

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			int_status_reg <= '0;
		end else if (wr_low && avs_address == REG_INT_STATUS) begin
			int_status_reg <= (int_status_reg & ~avs_writedata[N_EVT-1:0]) | evt_vec;
		end else begin
			int_status_reg <= int_status_reg | evt_vec;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			int_mask_reg <= MASK_RESET;
		end else if (wr_low && avs_address == REG_INT_MASK) begin
			int_mask_reg <= avs_writedata[N_EVT-1:0];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(int_status_reg & int_mask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// avalon-mm slave: one wait cycle, then read data and write effect

	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		unique case (avs_address)
			REG_CTRL: begin
				rd_mux[CTRL_AUTO_BIT] = ctrl_reg[CTRL_AUTO_BIT];
			end
			REG_STATUS: begin
				rd_mux[STS_MAIN_BIT] = main_power_enable_out;
				rd_mux[STS_READY_BIT] = ready_to_operate_out;
				rd_mux[STS_RTC_BIT] = ~rtc_n_sync;
				rd_mux[STS_BATT_BIT] = batt_sync;
				rd_mux[STS_STRAP_LSB +: STRAP_W] = strap_info.code;
				rd_mux[STS_RSVD_BIT] = strap_info.reserved;
				rd_mux[STS_STATE_LSB +: 2] = state_reg;
			end
			REG_INT_STATUS: begin
				rd_mux[N_EVT-1:0] = int_status_reg;
			end
			REG_INT_MASK: begin
				rd_mux[N_EVT-1:0] = int_mask_reg;
			end
			REG_CLOCK: begin
				rd_mux[CLOCK_CORE_LSB +: 16] = strap_info.pair.core_khz;
				rd_mux[CLOCK_BUS_LSB +: 16] = strap_info.pair.bus_khz;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= rd_mux;
		end
	end
endmodule

/* sim/pwr_init_sva.sv */
// port assertions of the power-on sequencer
`timescale 1ns/100ps
module pwr_init_sva
	import pwr_init_pkg::*;
#(
	parameter int CHECK_WAIT = 4
) (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic battery_inhibit_in,
	input wire logic power_switch_in,
	input wire logic rtc_reset_n_in,
	input wire logic carrier_detect_n_in,
	input wire logic main_power_enable_out,
	input wire logic ready_to_operate_out,
	input wire logic rtc_logic_reset_out,
	input wire logic [pwr_init_pkg::STRAP_W-1:0] clock_select_out,
	input wire pwr_init_pkg::clk_pair_t clock_pair_out
);
	localparam int RDY_MAX = CHECK_WAIT + 4;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	cause_ready_a: assert property (
		($rose(power_switch_in) || $fell(carrier_detect_n_in)) && rtc_reset_n_in && !rtc_logic_reset_out
		&& !main_power_enable_out && !ready_to_operate_out |-> ##[3:5] ready_to_operate_out)
		else $error("no ready after cause");
	ready_bound_a: assert property (
		$rose(ready_to_operate_out) |-> ##[1:RDY_MAX] !ready_to_operate_out)
		else $error("ready too long");
	batt_ok_a: assert property (
		battery_inhibit_in [*6] ##0 $fell(ready_to_operate_out) ##0 !rtc_logic_reset_out
		|-> main_power_enable_out)
		else $error("no main power after good check");
	batt_low_a: assert property (
		!battery_inhibit_in [*6] ##0 $fell(ready_to_operate_out) |-> !main_power_enable_out)
		else $error("main power despite low battery");
	alarm_off_a: assert property (
		main_power_enable_out && $fell(battery_inhibit_in) |-> ##[1:6] !main_power_enable_out)
		else $error("alarm did not cut power");
	rtc_hold_a: assert property (
		!rtc_reset_n_in [*5] |-> rtc_logic_reset_out && !main_power_enable_out)
		else $error("rtc logic not in reset");
	strap_keep_a: assert property (
		rtc_reset_n_in [*8] |-> $stable(clock_select_out))
		else $error("clock select moved");
	pair_map_a: assert property (
		clock_select_out == 3'h5 ##1 clock_select_out == 3'h5 |-> clock_pair_out == 32'hd160_1a2c)
		else $error("wrong clock pair");
endmodule
bind power_on_init_sequencer pwr_init_sva #(.CHECK_WAIT(CHECK_WAIT)) i_sva (.mclk_in, .rstn_in,
	.battery_inhibit_in, .power_switch_in, .rtc_reset_n_in, .carrier_detect_n_in, .main_power_enable_out,
	.ready_to_operate_out, .rtc_logic_reset_out, .clock_select_out, .clock_pair_out);

/* sim/pwr_agent.sv */
// model of the power agent, switches and shared strap pins
`timescale 1ns/100ps
module pwr_agent #(
	parameter int RTC_LOW = 30
) (
	input wire logic mclk_in,
	output logic batt_out,
	output logic pwr_sw_out,
	output logic btn_n_out,
	output logic rtc_n_out,
	output logic cd_n_out,
	output logic [2:0] strap_out
);
	logic hold_reg = 1'h1;
	initial begin
		batt_out = 1'h1;
		pwr_sw_out = 1'h0;
		btn_n_out = 1'h1;
		rtc_n_out = 1'h0;
		cd_n_out = 1'h1;
		strap_out = 3'h0;
	end
	// pins carry serial traffic once the strap hold has run out
	always @(posedge mclk_in) if (!hold_reg) strap_out <= strap_out + 3'h1;
	// only codes 000 to 101 are ever strapped
	task automatic rtc_pulse(input logic [2:0] code);
		@(posedge mclk_in);
		hold_reg <= 1'h1;
		@(posedge mclk_in);
		strap_out <= code;
		rtc_n_out <= 1'h0;
		repeat (RTC_LOW) @(posedge mclk_in);
		rtc_n_out <= 1'h1;
		repeat (6) @(posedge mclk_in);
		hold_reg <= 1'h0;
	endtask
	task automatic pulse(input int w);
		@(posedge mclk_in);
		if (w == 0) pwr_sw_out <= 1'h1;
		if (w == 1) cd_n_out <= 1'h0;
		if (w == 2) btn_n_out <= 1'h0;
		repeat (6) @(posedge mclk_in);
		pwr_sw_out <= 1'h0;
		cd_n_out <= 1'h1;
		btn_n_out <= 1'h1;
	endtask
	task automatic set_batt(input logic v);
		@(posedge mclk_in);
		batt_out <= v;
	endtask
endmodule

/* sim/test_power_on_init_sequencer.sv */
// self-checking bench of the power-on sequencer
`timescale 1ns/100ps
module test_power_on_init_sequencer;
	import pwr_init_pkg::*;
	logic mclk_in = 1'h0;
	logic rstn_in;
	logic batt, pwr_sw, btn_n, rtc_n, cd_n, wreq, main_pwr, ready, rtc_rst, irq;
	logic [STRAP_W-1:0] strap, sel;
	logic [ADDR_W-1:0] adr;
	logic rd_en;
	logic wr_en;
	logic [31:0] wdat;
	logic [3:0] be;
	logic [31:0] rdat, rd;
	clk_pair_t pair;
	int bad_count = 0;
	int samples_checked = 0;

	pwr_agent i_agent (.mclk_in(mclk_in), .batt_out(batt), .pwr_sw_out(pwr_sw), .btn_n_out(btn_n),
		.rtc_n_out(rtc_n), .cd_n_out(cd_n), .strap_out(strap));
	power_on_init_sequencer #(.CHECK_WAIT(4)) i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.battery_inhibit_in(batt), .power_switch_in(pwr_sw), .reset_button_n_in(btn_n),
		.rtc_reset_n_in(rtc_n), .carrier_detect_n_in(cd_n), .clock_select_strap_in(strap),
		.avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
		.main_power_enable_out(main_pwr), .ready_to_operate_out(ready), .rtc_logic_reset_out(rtc_rst),
		.clock_select_out(sel), .clock_pair_out(pair), .irq_out(irq));

	initial forever #10 mclk_in = ~mclk_in;

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge mclk_in);
		adr <= a;
		wdat <= wd;
		rd_en <= !w;
		wr_en <= w;
		// waitrequest only moves on rising edges, so its mid-cycle level is what the next edge samples
		@(negedge mclk_in);
		while (wreq !== 1'h0 && n < 50) begin
			@(negedge mclk_in);
			n++;
		end
		@(posedge mclk_in);
		rd = rdat;
		rd_en <= 1'h0;
		wr_en <= 1'h0;
		@(negedge mclk_in);
		if (n >= 50) chk("bus wait", 32'h1, 32'h0);
	endtask
	task automatic wt(input logic on, input logic v);
		int n;
		n = 0;
		while ((on ? main_pwr : ready) !== v && n < 40) begin
			@(negedge mclk_in);
			n++;
		end
		chk(on ? "main" : "ready", on ? main_pwr : ready, v);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		bus(0, REG_CTRL, 32'h0);
		chk("ctrl", rd, 32'h2);
		chk("rtc reset", rtc_rst, 1'h1);
		chk("main", main_pwr, 1'h0);
		bus(0, REG_INT_MASK, 32'h0);
		chk("mask", rd, 32'h0);
		// a write without byte lane 0 must leave the mask untouched
		@(posedge mclk_in);
		be <= 4'he;
		bus(1, REG_INT_MASK, 32'h3f);
		@(posedge mclk_in);
		be <= 4'hf;
		bus(0, REG_INT_MASK, 32'h0);
		chk("mask lane off", rd, 32'h0);
		bus(1, 5'h14, 32'hff);
		bus(0, 5'h14, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_strap();
		logic [31:0] tbl [6] = '{32'h8020_2008, 32'h9024_23f0, 32'ha474_149b, 32'hb158_162b,
			32'hc030_17bb, 32'hd160_1a2c};
		for (int c = 0; c < 6; c++) begin
			i_agent.rtc_pulse(c[2:0]);
			repeat (8) @(posedge mclk_in);
			chk("select", sel, c[2:0]);
			chk("pair", pair, tbl[c]);
			bus(0, REG_CLOCK, 32'h0);
			chk("clock reg", rd, tbl[c]);
		end
		$display("strap test done");
	endtask
	task automatic t_power_on(input int w);
		bus(1, REG_INT_STATUS, 32'h3f);
		fork
			i_agent.pulse(w);
		join_none
		wt(0, 1'h1);
		chk("main in check", main_pwr, 1'h0);
		wt(1, 1'h1);
		chk("ready after", ready, 1'h0);
		bus(0, REG_INT_STATUS, 32'h0);
		chk("events", rd, 32'h1);
		chk("irq masked", irq, 1'h0);
		bus(1, REG_INT_MASK, 32'h1);
		repeat (2) @(posedge mclk_in);
		chk("irq on", irq, 1'h1);
		bus(1, REG_INT_STATUS, 32'h1);
		repeat (2) @(posedge mclk_in);
		chk("irq cleared", irq, 1'h0);
		bus(1, REG_INT_MASK, 32'h0);
		$display("power on test done");
	endtask
	task automatic t_alarm();
		i_agent.set_batt(1'h0);
		wt(1, 1'h0);
		bus(0, REG_INT_STATUS, 32'h0);
		chk("alarm evt", rd[EVT_BATT_LOW], 1'h1);
		bus(1, REG_INT_STATUS, 32'h3f);
		fork
			i_agent.pulse(1);
		join_none
		wt(0, 1'h1);
		wt(0, 1'h0);
		repeat (3) @(posedge mclk_in);
		chk("main low batt", main_pwr, 1'h0);
		bus(0, REG_INT_STATUS, 32'h0);
		chk("low evt", rd[EVT_BATT_INHIBIT], 1'h1);
		i_agent.set_batt(1'h1);
		$display("battery test done");
	endtask
	task automatic t_off();
		bus(1, REG_CTRL, 32'h3);
		wt(1, 1'h0);
		t_power_on(0);
		i_agent.pulse(2);
		bus(0, REG_INT_STATUS, 32'h0);
		chk("button evt", rd[EVT_RESET_BTN], 1'h1);
		i_agent.rtc_pulse(3'h2);
		chk("rtc off", main_pwr, 1'h0);
		$display("off test done");
	endtask

	initial begin
		rstn_in = 1'h0;
		adr = 5'h00;
		rd_en = 1'h0;
		wr_en = 1'h0;
		wdat = 32'h0;
		be = 4'hf;
		repeat (20) @(posedge mclk_in);
		rstn_in <= 1'h1;
		t_reset();
		t_strap();
		t_power_on(0);
		t_alarm();
		t_power_on(1);
		t_off();
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		end_sim();
	end
endmodule
